// ### verilog/dcu_control_word.sv
// Upper half of the primary control word with its update timing and effects.
module dcu_control_word
	import dcu_pkg::*;
(
	// Clock and master reset.
	input wire logic sys_clk_in,
	input wire logic rst_in,
	// Programming port write and read.
	input wire logic wr_en_in,
	input wire logic [31:0] wr_data_in,
	output logic [31:0] rd_data_out,
	// Update strobe and pins.
	input wire logic io_update_in,
	input wire logic [PSEL_W-1:0] profile_select_pins_in,
	input wire logic [FSEL_W-1:0] function_select_pins_in,
	input wire logic [PORT_W-1:0] parallel_data_in,
	// Ramp enable from the secondary control word.
	input wire logic ramp_enable_in,
	// Effects on the core.
	output logic cal_start_out,
	output logic sine_select_out,
	output logic load_rate_out,
	output logic ramp_clear_out,
	output logic phase_clear_out,
	output logic stream_active_out,
	output logic [PORT_W-1:0] frequency_word_out,
	output logic [15:0] phase_offset_word_out,
	output logic [11:0] amplitude_word_out
);

	////////////////////////////////////////////////////////////////////////////////
	// State.

	typedef enum logic [1:0] {
		CAL_ARMED = 2'b01,
		CAL_SPENT = 2'b10
	} dcu_cal_t;

	logic [31:0] buf_q, buf_d;
	logic [31:0] act_q, act_d;
	logic [PSEL_W-1:0] ps_q, ps_d;
	dcu_cal_t cal_q, cal_d;
	dcu_ctrl_t ctrl_q, ctrl_d;
	logic [31:0] rd_q, rd_d;
	logic transfer;
	logic [PORT_W-1:0] freq_w;
	logic [15:0] phase_w;
	logic [11:0] amp_w;
	logic [PORT_W-1:0] freq_q;
	logic [15:0] phase_q;
	logic [11:0] amp_q;

	////////////////////////////////////////////////////////////////////////////////
	// Write buffer and transfer to the active copy.

	// A transfer happens on an update strobe or any profile pin change.
	always_comb begin
		transfer = io_update_in | (profile_select_pins_in != ps_q);
		ps_d = profile_select_pins_in;
		buf_d = buf_q;
		if (wr_en_in) begin
			buf_d = wr_data_in & WRITE_MASK;
		end
		act_d = act_q;
		if (transfer) begin
			act_d = buf_q;
		end
		rd_d = buf_d;
	end

	// Reset loads defaults so the host sees sine selected after master reset.
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			buf_q <= RESET_VALUE;
			act_q <= RESET_VALUE;
			ps_q <= 3'h0;
			rd_q <= RESET_VALUE;
		end else begin
			buf_q <= buf_d;
			act_q <= act_d;
			ps_q <= ps_d;
			rd_q <= rd_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Calibration trigger and accumulator controls.

	// Calibration starts once on a write of the bit while armed; the edge detector
	// ignores a repeated one until the host has written a zero.
	always_comb begin
		cal_d = cal_q;
		ctrl_d = '0;
		case (cal_q)
			CAL_ARMED: begin
				if (wr_en_in && wr_data_in[POS_CAL]) begin
					ctrl_d.cal_start = 1'b1;
					cal_d = CAL_SPENT;
				end
			end
			CAL_SPENT: begin
				if (wr_en_in && !wr_data_in[POS_CAL]) begin
					cal_d = CAL_ARMED;
				end
			end
			default: cal_d = CAL_ARMED;
		endcase
		// Rate reload needs the ramp generator enabled.
		ctrl_d.load_rate = transfer && ramp_enable_in && buf_q[POS_LOAD_RATE];
		// Static clears follow the active copy; auto clears pulse once per transfer.
		ctrl_d.ramp_clear = act_d[POS_CLR_RAMP] | (transfer & buf_q[POS_AUTOCLR_RAMP]);
		ctrl_d.phase_clear = act_d[POS_CLR_PHASE] | (transfer & buf_q[POS_AUTOCLR_PHASE]);
	end

	// Controls are registered so each takes effect on the next edge.
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			cal_q <= CAL_ARMED;
			ctrl_q <= '0;
		end else begin
			cal_q <= cal_d;
			ctrl_q <= ctrl_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Parallel port.

	// Streaming mode is taken from the active copy of bit 17.
	dcu_port_router u_router (
		.sys_clk_in(sys_clk_in),
		.rst_in(rst_in),
		.stream_en_in(act_q[POS_STREAM]),
		.update_in(io_update_in),
		.data_in(parallel_data_in),
		.fsel_in(function_select_pins_in),
		.freq_out(freq_w),
		.phase_out(phase_w),
		.amp_out(amp_w)
	);

	// Words are already registered inside the router.
	assign freq_q = freq_w;
	assign phase_q = phase_w;
	assign amp_q = amp_w;

	////////////////////////////////////////////////////////////////////////////////
	// Outputs.

	assign rd_data_out = rd_q;
	assign cal_start_out = ctrl_q.cal_start;
	assign sine_select_out = act_q[POS_SINE];
	assign load_rate_out = ctrl_q.load_rate;
	assign ramp_clear_out = ctrl_q.ramp_clear;
	assign phase_clear_out = ctrl_q.phase_clear;
	assign stream_active_out = act_q[POS_STREAM];
	assign frequency_word_out = freq_q;
	assign phase_offset_word_out = phase_q;
	assign amplitude_word_out = amp_q;

	////////////////////////////////////////////////////////////////////////////////
	// Checks.

	cal_edge_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		cal_q == CAL_ARMED && wr_en_in && wr_data_in[POS_CAL] |=> cal_start_out)
		else $error("calibration not started on rising bit");
	cal_once_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		cal_q == CAL_SPENT |=> !cal_start_out)
		else $error("calibration repeated without zero");
	sine_hold_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		!transfer |=> $stable(sine_select_out))
		else $error("sine select moved without transfer");
	rate_gate_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		!ramp_enable_in |=> !load_rate_out)
		else $error("rate loaded while ramp disabled");
	rate_load_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		transfer && ramp_enable_in && buf_q[POS_LOAD_RATE] |=> load_rate_out)
		else $error("rate not loaded on transfer");
	ramp_pulse_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		transfer && buf_q[POS_AUTOCLR_RAMP] && !buf_q[POS_CLR_RAMP] ##1 !transfer
		|=> !ramp_clear_out)
		else $error("ramp auto clear longer than one cycle");
	phase_auto_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		transfer && buf_q[POS_AUTOCLR_PHASE] |=> phase_clear_out)
		else $error("phase auto clear missing");
	ramp_static_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		act_q[POS_CLR_RAMP] && !transfer |=> ramp_clear_out)
		else $error("ramp not held at zero");
	phase_static_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		act_q[POS_CLR_PHASE] && !transfer |=> phase_clear_out)
		else $error("phase not held at zero");
	open_bits_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		(rd_data_out & ~WRITE_MASK) == 32'h00000000)
		else $error("open bit read nonzero");
	transfer_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		transfer |=> act_q == $past(buf_q))
		else $error("buffer not transferred");

	cal_c: cover property (@(posedge sys_clk_in) cal_start_out);
	stream_c: cover property (@(posedge sys_clk_in) stream_active_out);
	rate_c: cover property (@(posedge sys_clk_in) load_rate_out);
	phase_c: cover property (@(posedge sys_clk_in) phase_clear_out && !act_q[POS_CLR_PHASE]);

endmodule

// ### shared/dcu_pkg.sv
// Package with bit positions, reset values and carrier types for the upper control word.
package dcu_pkg;

	// Bit positions within the primary control word.
	localparam int POS_CAL = 24;
	localparam int POS_STREAM = 17;
	localparam int POS_SINE = 16;
	localparam int POS_LOAD_RATE = 15;
	localparam int POS_AUTOCLR_RAMP = 14;
	localparam int POS_AUTOCLR_PHASE = 13;
	localparam int POS_CLR_RAMP = 12;
	localparam int POS_CLR_PHASE = 11;
	localparam int POS_RAMP_EN_SEC = 19;

	// Writable bits of the upper half; all others read as zero.
	localparam logic [31:0] WRITE_MASK = 32'h0103F800;
	// Reset value: only the sine select is set.
	localparam logic [31:0] RESET_VALUE = 32'h00010000;

	// Widths of the parallel port and select pins.
	localparam int PORT_W = 32;
	localparam int FSEL_W = 4;
	localparam int PSEL_W = 3;

	// Function select codes steering a streamed word.
	localparam logic [3:0] FSEL_FREQ = 4'h0;
	localparam logic [3:0] FSEL_PHASE = 4'h1;
	localparam logic [3:0] FSEL_AMP = 4'h2;

	// Destination of a parallel word.
	typedef enum logic [2:0] {
		DEST_FREQ = 3'b001,
		DEST_PHASE = 3'b010,
		DEST_AMP = 3'b100
	} dcu_dest_t;

	// Control strobes sent to the accumulators and ramp timer.
	typedef struct packed {
		logic cal_start;
		logic load_rate;
		logic ramp_clear;
		logic phase_clear;
	} dcu_ctrl_t;

	// Decodes the function select pins to a destination.
	function automatic dcu_dest_t fsel_decode(input logic [3:0] fsel);
		case (fsel)
			FSEL_PHASE: fsel_decode = DEST_PHASE;
			FSEL_AMP: fsel_decode = DEST_AMP;
			default: fsel_decode = DEST_FREQ;
		endcase
	endfunction

endpackage

// ### verilog/dcu_port_router.sv
// Parallel port router: strobed or streamed capture of data words.
module dcu_port_router
	import dcu_pkg::*;
(
	// Clock and reset.
	input wire logic sys_clk_in,
	input wire logic rst_in,
	// Mode and data.
	input wire logic stream_en_in,
	input wire logic update_in,
	input wire logic [PORT_W-1:0] data_in,
	input wire logic [FSEL_W-1:0] fsel_in,
	// Routed words.
	output logic [PORT_W-1:0] freq_out,
	output logic [15:0] phase_out,
	output logic [11:0] amp_out
);

	logic [PORT_W-1:0] freq_q, freq_d;
	logic [15:0] phase_q, phase_d;
	logic [11:0] amp_q, amp_d;
	logic take;

	// Streaming samples every edge; otherwise only the update strobe loads a word.
	always_comb begin
		take = stream_en_in | update_in;
		freq_d = freq_q;
		phase_d = phase_q;
		amp_d = amp_q;
		if (take) begin
			case (fsel_decode(fsel_in))
				DEST_PHASE: phase_d = data_in[15:0];
				DEST_AMP: amp_d = data_in[11:0];
				default: freq_d = data_in;
			endcase
		end
	end

	// Word registers.
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			freq_q <= 32'h00000000;
			phase_q <= 16'h0000;
			amp_q <= 12'h000;
		end else begin
			freq_q <= freq_d;
			phase_q <= phase_d;
			amp_q <= amp_d;
		end
	end

	assign freq_out = freq_q;
	assign phase_out = phase_q;
	assign amp_out = amp_q;

	// Strobe mode must not move the frequency or phase word when no update is given.
	hold_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		!stream_en_in && !update_in |=> $stable(freq_q) && $stable(phase_q))
		else $error("word changed without update in strobe mode");

	// Streaming captures a frequency word on the next edge.
	stream_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		stream_en_in && fsel_in == FSEL_FREQ |=> freq_q == $past(data_in))
		else $error("streamed word not captured");

endmodule

// ### sim/dcu_host_model.sv
// Host controller model that programs the control word and drives the pins.
module dcu_host_model
	import dcu_pkg::*;
(
	// Clock.
	input wire logic sys_clk_in,
	// Programming port.
	output logic wr_en_out,
	output logic [31:0] wr_data_out,
	output logic io_update_out,
	// Pins and parallel port.
	output logic [PSEL_W-1:0] psel_out,
	output logic [FSEL_W-1:0] fsel_out,
	output logic [PORT_W-1:0] pdata_out
);
	timeunit 1ns;
	timeprecision 1ps;

	// Everything idle at time zero.
	initial begin
		wr_en_out = 1'b0;
		wr_data_out = 32'h0;
		io_update_out = 1'b0;
		psel_out = 3'h0;
		fsel_out = 4'h0;
		pdata_out = 32'h0;
	end

	// One write; data is inverted after release so a stale word never looks valid.
	task automatic write(input logic [31:0] d);
		@(negedge sys_clk_in);
		wr_en_out = 1'b1;
		wr_data_out = d;
		@(negedge sys_clk_in);
		wr_en_out = 1'b0;
		wr_data_out = ~d;
	endtask

	// One update strobe, one cycle long.
	task automatic update();
		@(negedge sys_clk_in);
		io_update_out = 1'b1;
		@(negedge sys_clk_in);
		io_update_out = 1'b0;
	endtask

	// Changes at the falling edge keep the word stable around the rising edge.
	task automatic present(input logic [3:0] f, input logic [31:0] d);
		@(negedge sys_clk_in);
		fsel_out = f;
		pdata_out = d;
		@(negedge sys_clk_in);
	endtask

	// Moves the profile pins to a new value.
	task automatic profile(input logic [2:0] p);
		@(negedge sys_clk_in);
		psel_out = p;
		@(negedge sys_clk_in);
	endtask
endmodule

// ### sim/testbench.sv
// Self-checking testbench for the upper control word.
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import dcu_pkg::*;

	logic sys_clk_in, rst_in, ramp_en, wr_en, upd;
	logic cal, sine, lrate, rclr, pclr, strm;
	logic [31:0] wr_data, rd, pdata, freq;
	logic [2:0] psel;
	logic [3:0] fsel;
	logic [15:0] ph;
	logic [11:0] amplitude_word;
	int failures = 0;
	int total_checks = 0;

	dcu_host_model i_dcu_host_model(.sys_clk_in(sys_clk_in), .wr_en_out(wr_en),
		.wr_data_out(wr_data), .io_update_out(upd), .psel_out(psel), .fsel_out(fsel),
		.pdata_out(pdata));

	dcu_control_word i_dcu_control_word(.sys_clk_in(sys_clk_in), .rst_in(rst_in),
		.wr_en_in(wr_en), .wr_data_in(wr_data), .rd_data_out(rd), .io_update_in(upd),
		.profile_select_pins_in(psel), .function_select_pins_in(fsel),
		.parallel_data_in(pdata), .ramp_enable_in(ramp_en), .cal_start_out(cal),
		.sine_select_out(sine), .load_rate_out(lrate), .ramp_clear_out(rclr),
		.phase_clear_out(pclr), .stream_active_out(strm), .frequency_word_out(freq),
		.phase_offset_word_out(ph), .amplitude_word_out(amplitude_word));

	// Clock at 100 MHz.
	initial begin
		sys_clk_in = 1'b0;
		forever #5 sys_clk_in = ~sys_clk_in;
	end

	// Compares one value; four-state equality so an unknown never matches.
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Prints the verdict and ends the run.
	task automatic print_verdict();
		if (failures == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// The sequence needs under a hundred cycles; this limit is far beyond it.
	initial begin
		#20000;
		failures++;
		print_verdict();
	end

	// Main sequence.
	initial begin
		rst_in = 1'b1;
		ramp_en = 1'b0;
		repeat (3) @(negedge sys_clk_in);
		check(rd, RESET_VALUE);
		check({cal, sine, lrate, rclr, pclr, strm}, 6'h10);
		rst_in = 1'b0;
		i_dcu_host_model.write(32'hFFFFFFFF);
		check(rd, WRITE_MASK);
		check(cal, 1'b1);
		check(strm, 1'b0);
		@(negedge sys_clk_in);
		check(cal, 1'b0);
		i_dcu_host_model.write(32'hFFFFFFFF);
		check(cal, 1'b0);
		i_dcu_host_model.write(32'h0);
		check(sine, 1'b1);
		i_dcu_host_model.write(32'h01000000);
		check(cal, 1'b1);
		i_dcu_host_model.write(32'h0);
		i_dcu_host_model.update();
		check(sine, 1'b0);
		// Auto clears pulse on every update while their bits are written; rate reload only while the ramp is enabled.
		ramp_en = 1'b1;
		i_dcu_host_model.write(32'h0001E000);
		i_dcu_host_model.update();
		check(sine, 1'b1);
		check({lrate, rclr, pclr}, 3'h7);
		i_dcu_host_model.update();
		check({lrate, rclr, pclr}, 3'h7);
		@(negedge sys_clk_in);
		check({lrate, rclr, pclr}, 3'h0);
		i_dcu_host_model.profile(3'h5);
		check({lrate, rclr, pclr}, 3'h7);
		ramp_en = 1'b0;
		i_dcu_host_model.update();
		check({lrate, rclr, pclr}, 3'h3);
		// Static clears hold while their bits stay active.
		i_dcu_host_model.write(32'h00011800);
		i_dcu_host_model.update();
		repeat (3) @(negedge sys_clk_in);
		check({lrate, rclr, pclr}, 3'h3);
		i_dcu_host_model.write(32'h00010000);
		i_dcu_host_model.update();
		repeat (2) @(negedge sys_clk_in);
		check({rclr, pclr}, 2'h0);
		// Strobe mode: the port word waits for an update.
		i_dcu_host_model.present(FSEL_FREQ, 32'h12345678);
		check(freq, 32'h0);
		i_dcu_host_model.update();
		check(freq, 32'h12345678);
		i_dcu_host_model.present(FSEL_PHASE, 32'h00004321);
		i_dcu_host_model.update();
		check(ph, 16'h4321);
		i_dcu_host_model.present(FSEL_AMP, 32'h00000ABC);
		i_dcu_host_model.update();
		check(amplitude_word, 12'hABC);
		// Streaming: every edge captures, routed by the select pins.
		i_dcu_host_model.write(32'h00030000);
		i_dcu_host_model.update();
		check(strm, 1'b1);
		for (int i = 0; i < 3; i++) begin
			i_dcu_host_model.present(FSEL_FREQ, 32'hA5A50000 + 32'(i));
			check(freq, 32'hA5A50000 + 32'(i));
		end
		i_dcu_host_model.present(FSEL_PHASE, 32'h00001234);
		check(ph, 16'h1234);
		i_dcu_host_model.present(FSEL_AMP, 32'h00000567);
		check(amplitude_word, 12'h567);
		// Unassigned select codes steer the word to the frequency register.
		i_dcu_host_model.present(4'h7, 32'h0BADF00D);
		check(freq, 32'h0BADF00D);
		check(amplitude_word, 12'h567);
		// A mid-run master reset restores defaults and re-arms calibration.
		i_dcu_host_model.write(32'h01030000);
		check(cal, 1'b1);
		rst_in = 1'b1;
		@(negedge sys_clk_in);
		check(rd, RESET_VALUE);
		check({cal, sine, lrate, rclr, pclr, strm}, 6'h10);
		check(freq, 32'h0);
		check({ph, amplitude_word}, 28'h0);
		rst_in = 1'b0;
		i_dcu_host_model.write(32'h01000000);
		check(cal, 1'b1);
		check(strm, 1'b0);
		check(sine, 1'b1);
		print_verdict();
	end
endmodule
